// File: hdl/adc_host_end.sv
// controller end: register slave, write strobes, conversion start and power-up waits
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_host_end #(
   parameter int unsigned PWRUP_LONG_CYC = `PWRUP_LONG_CYC
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // register slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // link to the converter
   adc_port_if.host port
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      adc_port_pkg::host_state_t state;
      logic [`DATA_W-1:0] word;
      logic [1:0] pm;
      logic word_mode;
      logic ext_ref;
      logic shadow_sel;
      logic high_pass;
      logic [2:0] cnt;
      logic [`TIMER_W-1:0] timer;
      logic seen_busy;
      logic cs_n;
      logic [`DATA_W-1:0] data;
      logic conversion_start_n_n;
      logic cclk;
      logic [2:0] div;
      logic rd_ack;
      logic [31:0] rdata;
   } host_t;

   host_t st_ff;
   host_t nxt_st;
   logic idle;
   logic wr_take;
   logic auto_mode;
   logic [`TIMER_W-1:0] wake_t;

   localparam logic [`TIMER_W-1:0] LONG_T = `TIMER_W'(PWRUP_LONG_CYC);
   localparam logic [`TIMER_W-1:0] EXT_T = `TIMER_W'(`PWRUP_EXT_CYC);
   localparam logic [`TIMER_W-1:0] ACQ_T = `TIMER_W'(`ACQ_CYC);

   assign idle = (st_ff.state == adc_port_pkg::H_IDLE);
   assign wr_take = avs_write & idle;
   assign auto_mode = (st_ff.pm == 2'h1) || (st_ff.pm == 2'h2);
   assign avs_waitrequest = (avs_read & ~st_ff.rd_ack) | (avs_write & ~idle);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      wake_t = '0;
      nxt_st.rd_ack = avs_read & ~st_ff.rd_ack;
      if (avs_read & ~st_ff.rd_ack) begin
         case (avs_address)
            `REG_CTRL: nxt_st.rdata = {20'h00000, st_ff.word};
            `REG_CFG: nxt_st.rdata = {30'h00000000, st_ff.ext_ref, st_ff.word_mode};
            `REG_STATUS: nxt_st.rdata = {28'h0000000, st_ff.pm, port.busy, ~idle};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
      // free-running conversion clock from a divider
      if (st_ff.div == `CCLK_HALF_CYC - 3'h1) begin
         nxt_st.div = 3'h0;
         nxt_st.cclk = ~st_ff.cclk;
      end else begin
         nxt_st.div = st_ff.div + 3'h1;
      end
      if (st_ff.timer != '0) begin
         nxt_st.timer = st_ff.timer - `TIMER_W'(1);
      end

      case (st_ff.state)
         adc_port_pkg::H_IDLE: begin
            if (wr_take) begin
               case (avs_address)
                  `REG_CTRL: begin
                     nxt_st.word = avs_writedata[`DATA_W-1:0];
                     nxt_st.shadow_sel = 1'b0;
                     nxt_st.high_pass = 1'b0;
                     nxt_st.state = adc_port_pkg::H_STROBE;
                  end
                  `REG_SHADOW: begin
                     nxt_st.word = {4'h0, avs_writedata[7:0]};
                     nxt_st.shadow_sel = 1'b1;
                     nxt_st.high_pass = 1'b0;
                     nxt_st.state = adc_port_pkg::H_STROBE;
                  end
                  `REG_CFG: begin
                     nxt_st.word_mode = avs_writedata[`CFG_WORD_BIT];
                     nxt_st.ext_ref = avs_writedata[`CFG_EXTREF_BIT];
                  end
                  `REG_CONV: begin
                     // a start request in full shutdown is dropped
                     if (st_ff.pm != 2'h3) begin
                        nxt_st.state = adc_port_pkg::H_SETTLE;
                        if (!st_ff.conversion_start_n_n) begin
                           nxt_st.conversion_start_n_n = 1'b1;
                           if (!auto_mode) begin
                              wake_t = ACQ_T;
                           end else if (st_ff.pm == 2'h2 && st_ff.ext_ref) begin
                              wake_t = EXT_T;
                           end else begin
                              wake_t = LONG_T;
                           end
                           // a pending wake from full shutdown is never shortened by a later start
                           if (st_ff.timer < wake_t) begin
                              nxt_st.timer = wake_t;
                           end
                        end
                     end
                  end
                  default: begin
                     nxt_st.state = adc_port_pkg::H_IDLE;
                  end
               endcase
            end
         end
         adc_port_pkg::H_STROBE: begin
            nxt_st.cs_n = 1'b0;
            if (st_ff.shadow_sel || st_ff.word_mode) begin
               nxt_st.data = st_ff.word;
            end else if (!st_ff.high_pass) begin
               nxt_st.data = {4'h0, st_ff.word[7:0]};
            end else begin
               nxt_st.data = {4'h1, 4'h0, st_ff.word[11:8]};
            end
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == `WR_LOW_CYC) begin
               nxt_st.cs_n = 1'b1;
               nxt_st.data = st_ff.data;
               nxt_st.cnt = 3'h0;
               nxt_st.state = adc_port_pkg::H_RELEASE;
            end
         end
         adc_port_pkg::H_RELEASE: begin
            nxt_st.data = '0;
            nxt_st.state = adc_port_pkg::H_IDLE;
            if (!st_ff.shadow_sel && !st_ff.word_mode && !st_ff.high_pass) begin
               nxt_st.high_pass = 1'b1;
               nxt_st.state = adc_port_pkg::H_STROBE;
            end else if (!st_ff.shadow_sel) begin
               nxt_st.pm = {st_ff.word[`PM_HI_BIT], st_ff.word[`PM_LO_BIT]};
               if (st_ff.pm == 2'h3 && nxt_st.pm != 2'h3) begin
                  nxt_st.timer = LONG_T;
               end
            end
         end
         adc_port_pkg::H_SETTLE: begin
            if (st_ff.timer == '0) begin
               nxt_st.conversion_start_n_n = 1'b0;
               nxt_st.seen_busy = 1'b0;
               nxt_st.state = adc_port_pkg::H_CONVERT;
            end
         end
         adc_port_pkg::H_CONVERT: begin
            if (port.busy) begin
               nxt_st.seen_busy = 1'b1;
            end else if (st_ff.seen_busy) begin
               // start stays low in auto modes so the next wake is a clean rise
               nxt_st.conversion_start_n_n = ~auto_mode;
               nxt_st.timer = ACQ_T;
               nxt_st.state = adc_port_pkg::H_IDLE;
            end
         end
         default: begin
            nxt_st.state = adc_port_pkg::H_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '0;
         st_ff.state <= adc_port_pkg::H_IDLE;
         st_ff.cs_n <= 1'b1;
         st_ff.word_mode <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign port.cs_n = st_ff.cs_n;
   assign port.wr_n = st_ff.cs_n;
   assign port.word_mode = st_ff.word_mode;
   assign port.shadow_sel = st_ff.shadow_sel;
   assign port.data_bus = st_ff.data;
   assign port.conversion_start_n = st_ff.conversion_start_n_n;
   assign port.conversion_clock_in = st_ff.cclk;
   assign avs_readdata = st_ff.rdata;
endmodule

// File: hdl/adc_port_defines.svh
// offsets, field positions, reset values and timing counts of the converter port
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH
// ----------------------------------------
// link widths and fields
// ----------------------------------------
`define DATA_W 12
`define HBE_BIT 8
`define PM_LO_BIT 0
`define PM_HI_BIT 1
`define CTRL_RST 12'h000
`define SHADOW_RST 8'h00
`define CONV_FALL_EDGES 4'he
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 8
`define PWRUP_LONG_MS 10
`define PWRUP_EXT_NS 600
`define ACQ_NS 125
`define PWRUP_EXT_CYC ((`PWRUP_EXT_NS + `CLK_NS - 1) / `CLK_NS)
`define ACQ_CYC ((`ACQ_NS + `CLK_NS - 1) / `CLK_NS)
`define PWRUP_LONG_CYC (`PWRUP_LONG_MS * 1000000 / `CLK_NS)
`define WR_LOW_CYC 3'h3
`define CCLK_HALF_CYC 3'h4
`define TIMER_W 21
// ----------------------------------------
// controller register map (byte addresses)
// ----------------------------------------
`define REG_CTRL 5'h00
`define REG_SHADOW 5'h04
`define REG_CFG 5'h08
`define REG_CONV 5'h0c
`define REG_STATUS 5'h10
`define CFG_WORD_BIT 0
`define CFG_EXTREF_BIT 1
`endif

// File: hdl/adc_port_pkg.sv
// types shared by both ends of the converter port
package adc_port_pkg;
   typedef enum logic [1:0] {PM_NORMAL, PM_AUTO_SHUTDOWN, PM_AUTO_STANDBY, PM_FULL_SHUTDOWN} pm_t;
   typedef enum logic [2:0] {D_INIT_HOLD, D_TRACK, D_CONVERT, D_AUTO_SD, D_AUTO_SB, D_FULL_SD} dev_state_t;
   typedef enum logic [2:0] {H_IDLE, H_STROBE, H_RELEASE, H_SETTLE, H_CONVERT} host_state_t;
endpackage

// File: hdl/adc_port_if.sv
// parallel write port and conversion control lines between controller and converter
`timescale 1ns/100ps
`include "adc_port_defines.svh"
interface adc_port_if;
   logic cs_n;
   logic wr_n;
   logic word_mode;
   logic shadow_sel;
   logic [`DATA_W-1:0] data_bus;
   logic conversion_start_n;
   logic conversion_clock_in;
   logic busy;
   modport dev (input cs_n, wr_n, word_mode, shadow_sel, data_bus, conversion_start_n,
      conversion_clock_in, output busy);
   modport host (output cs_n, wr_n, word_mode, shadow_sel, data_bus, conversion_start_n,
      conversion_clock_in, input busy);
endinterface

// File: hdl/edge_detect.sv
// rise and fall detection for a group of synchronous inputs
`timescale 1ns/100ps
module edge_detect #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // levels in, edges out
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   typedef struct packed {
      logic [W-1:0] prev;
   } ed_state_t;
   ed_state_t st_ff;
   ed_state_t nxt_st;
   always_comb begin
      nxt_st.prev = level_i;
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign rise_o[i] = level_i[i] & ~st_ff.prev[i];
         assign fall_o[i] = ~level_i[i] & st_ff.prev[i];
      end
   endgenerate
endmodule

// File: hdl/adc_device_end.sv
// converter end: write port, control and shadow registers, power modes, busy
`timescale 1ns/100ps
`include "adc_port_defines.svh"
// Function
// - word mode: whole twelve bits in one write
// - byte mode: line 8 marks high or low byte
// - host writes low byte first, then high
// - high byte: lines 0-3 carry bits 11:8
// - shadow register loaded by one write
// - host drives top high-byte bits zero
// - data latched on write strobe rising edge
// - write only while select and strobe low
// - reset gives normal mode, always powered
// - after reset hold; first start rise tracks
// - auto shutdown: all off, hold after conversion
// - auto shutdown wakes on start rising edge
// - host waits 10 ms after shutdown wake
// - host idles start low in auto shutdown
// - auto standby: only reference stays powered
// - full shutdown entered at write strobe rise
// - control contents kept through power-down
// - normal written in shutdown wakes; 10 ms
// - start fall converts; busy high until end
module adc_device_end (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // link to the controller
   adc_port_if.dev port,
   // register contents
   output logic [`DATA_W-1:0] control_word_o,
   output logic [7:0] shadow_o,
   output logic power_mode_upper_bit_o,
   output logic power_mode_lower_bit_o,
   // power and track-and-hold status
   output logic powered_o,
   output logic reference_on_o,
   output logic tracking_o,
   output logic sample_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      adc_port_pkg::dev_state_t state;
      logic [`DATA_W-1:0] ctrl;
      logic [7:0] low_hold;
      logic [7:0] shadow;
      logic [3:0] edge_cnt;
      logic busy;
      logic powered;
      logic ref_on;
      logic tracking;
      logic sample;
   } dev_t;

   dev_t st_ff;
   dev_t nxt_st;

   logic strobe_n;
   logic [2:0] lvl;
   logic [2:0] rise;
   logic [2:0] fall;
   logic wr_done;
   logic start_rise;
   logic start_fall;
   logic cclk_fall;
   logic high_byte_enable;
   logic ctrl_written;
   adc_port_pkg::pm_t pm_new;
   adc_port_pkg::pm_t pm_cur;

   // ----------------------------------------
   // pin edges
   // ----------------------------------------
   // select and strobe are merged first so a tied pair still gives one edge
   assign strobe_n = port.cs_n | port.wr_n;
   // strobe enters inverted: the detector resets to 0 and the strobe idles high, so no false write after reset
   assign lvl = {port.conversion_clock_in, port.conversion_start_n, ~strobe_n};

   edge_detect #(
      .W(3)
   ) u_edges (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .level_i(lvl),
      .rise_o(rise),
      .fall_o(fall)
   );

   assign wr_done = fall[0];
   assign start_rise = rise[1];
   assign start_fall = fall[1];
   assign cclk_fall = fall[2];
   assign high_byte_enable = port.data_bus[`HBE_BIT];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      ctrl_written = 1'b0;
      nxt_st.sample = 1'b0;
      // registers change only on a write, never on a power transition
      if (wr_done) begin
         if (port.shadow_sel) begin
            nxt_st.shadow = port.data_bus[7:0];
         end else if (port.word_mode) begin
            nxt_st.ctrl = port.data_bus;
            ctrl_written = 1'b1;
         end else if (!high_byte_enable) begin
            nxt_st.low_hold = port.data_bus[7:0];
         end else begin
            nxt_st.ctrl = {port.data_bus[3:0], st_ff.low_hold};
            ctrl_written = 1'b1;
         end
      end
      pm_cur = adc_port_pkg::pm_t'({st_ff.ctrl[`PM_HI_BIT], st_ff.ctrl[`PM_LO_BIT]});
      pm_new = adc_port_pkg::pm_t'({nxt_st.ctrl[`PM_HI_BIT], nxt_st.ctrl[`PM_LO_BIT]});

      case (st_ff.state)
         adc_port_pkg::D_INIT_HOLD: begin
            if (start_rise) begin
               nxt_st.state = adc_port_pkg::D_TRACK;
            end
         end
         adc_port_pkg::D_TRACK: begin
            if (start_fall) begin
               nxt_st.state = adc_port_pkg::D_CONVERT;
               nxt_st.edge_cnt = 4'h0;
               nxt_st.sample = 1'b1;
            end
         end
         adc_port_pkg::D_CONVERT: begin
            if (cclk_fall) begin
               nxt_st.edge_cnt = st_ff.edge_cnt + 4'h1;
               if (st_ff.edge_cnt == `CONV_FALL_EDGES - 4'h1) begin
                  case (pm_cur)
                     adc_port_pkg::PM_NORMAL: nxt_st.state = adc_port_pkg::D_TRACK;
                     adc_port_pkg::PM_AUTO_SHUTDOWN: nxt_st.state = adc_port_pkg::D_AUTO_SD;
                     adc_port_pkg::PM_AUTO_STANDBY: nxt_st.state = adc_port_pkg::D_AUTO_SB;
                     default: nxt_st.state = adc_port_pkg::D_FULL_SD;
                  endcase
               end
            end
         end
         adc_port_pkg::D_AUTO_SD: begin
            if (start_rise) begin
               nxt_st.state = adc_port_pkg::D_TRACK;
            end
         end
         adc_port_pkg::D_AUTO_SB: begin
            if (start_rise) begin
               nxt_st.state = adc_port_pkg::D_TRACK;
            end
         end
         adc_port_pkg::D_FULL_SD: begin
            // left only by a write that changes the mode bits, handled below
            nxt_st.state = adc_port_pkg::D_FULL_SD;
         end
         default: begin
            nxt_st.state = adc_port_pkg::D_INIT_HOLD;
         end
      endcase

      // a completed control write takes priority over the conversion sequence
      if (ctrl_written) begin
         if (pm_new == adc_port_pkg::PM_FULL_SHUTDOWN) begin
            nxt_st.state = adc_port_pkg::D_FULL_SD;
         end else if (st_ff.state == adc_port_pkg::D_FULL_SD) begin
            nxt_st.state = adc_port_pkg::D_TRACK;
         end
      end

      nxt_st.busy = (nxt_st.state == adc_port_pkg::D_CONVERT);
      nxt_st.tracking = (nxt_st.state == adc_port_pkg::D_TRACK);
      nxt_st.powered = (nxt_st.state != adc_port_pkg::D_AUTO_SD) &&
         (nxt_st.state != adc_port_pkg::D_AUTO_SB) &&
         (nxt_st.state != adc_port_pkg::D_FULL_SD);
      nxt_st.ref_on = (nxt_st.state != adc_port_pkg::D_AUTO_SD) &&
         (nxt_st.state != adc_port_pkg::D_FULL_SD);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_ff.state <= adc_port_pkg::D_INIT_HOLD;
         st_ff.ctrl <= `CTRL_RST;
         st_ff.low_hold <= 8'h00;
         st_ff.shadow <= `SHADOW_RST;
         st_ff.edge_cnt <= 4'h0;
         st_ff.busy <= 1'b0;
         st_ff.powered <= 1'b1;
         st_ff.ref_on <= 1'b1;
         st_ff.tracking <= 1'b0;
         st_ff.sample <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign port.busy = st_ff.busy;
   assign control_word_o = st_ff.ctrl;
   assign shadow_o = st_ff.shadow;
   assign power_mode_upper_bit_o = st_ff.ctrl[`PM_HI_BIT];
   assign power_mode_lower_bit_o = st_ff.ctrl[`PM_LO_BIT];
   assign powered_o = st_ff.powered;
   assign reference_on_o = st_ff.ref_on;
   assign tracking_o = st_ff.tracking;
   assign sample_o = st_ff.sample;
endmodule

// File: verif/adc_port_asserts.sv
// concurrent checks on the lines between controller and converter
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_port_checker (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // port lines
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic word_mode,
   input wire logic shadow_sel,
   input wire logic [`DATA_W-1:0] data_bus,
   input wire logic conversion_start_n,
   input wire logic conversion_clock_in,
   input wire logic busy
);
   // ----------------------------------------
   // helper: length of the busy pulse
   // ----------------------------------------
   logic [7:0] busy_cnt_ff;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         busy_cnt_ff <= 8'h00;
      end else begin
         busy_cnt_ff <= busy ? busy_cnt_ff + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ----------------------------------------
   // write cycle
   // ----------------------------------------
   a_strobe_tied: assert property (cs_n == wr_n)
      else $error("select and strobe differ");
   a_strobe_low_len: assert property ($fell(cs_n) |=> !cs_n [*2] ##1 cs_n)
      else $error("strobe low length wrong");
   a_data_hold: assert property (!$past(cs_n) |-> $stable(data_bus))
      else $error("data moved around strobe rise");
   a_mode_hold: assert property (!$past(cs_n) |-> $stable(word_mode) && $stable(shadow_sel))
      else $error("mode moved during write");
   a_top_bits_zero: assert property (!cs_n && !word_mode && data_bus[`HBE_BIT] |-> data_bus[7:4] == 4'h0)
      else $error("high byte top bits not zero");
   a_low_byte_first: assert property ($fell(cs_n) && !word_mode && !shadow_sel && !data_bus[`HBE_BIT]
      |-> ##[2:30] ($fell(cs_n) && data_bus[`HBE_BIT]))
      else $error("high byte did not follow low byte");
   // ----------------------------------------
   // conversion
   // ----------------------------------------
   a_start_busy: assert property ($fell(conversion_start_n) |-> ##[1:4] busy)
      else $error("busy did not follow start fall");
   a_busy_start_low: assert property (busy |-> !conversion_start_n)
      else $error("busy high with start high");
   a_busy_len: assert property ($fell(busy) |-> busy_cnt_ff >= 8'h64 && busy_cnt_ff <= 8'h7d)
      else $error("busy length out of range");
endmodule

// File: verif/tb_adc_write_port_power_modes.sv
// bench driving the controller registers and watching the converter end
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module tb_adc_write_port_power_modes;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [11:0] control_word;
   logic [7:0] shadow;
   logic pm_hi;
   logic pm_lo;
   logic powered;
   logic reference_on;
   logic tracking;
   logic sample;
   logic [31:0] rd;
   logic [11:0] cw;
   logic [2:0] pwr_exp [4] = '{3'b111, 3'b000, 3'b010, 3'b000};
   int bad_count = 0;
   int n_compared = 0;
   int n_sample = 0;
   int cyc = 0;
   int t0;
   always #4 core_clk_i = ~core_clk_i;
   // cycle count and conversion-start pulses, seen at each rising edge
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (sample === 1'b1) begin
         n_sample <= n_sample + 1;
      end
   end
   adc_port_if adc_port_if_inst ();
   // short power-up wait keeps the run small
   adc_host_end #(.PWRUP_LONG_CYC(200)) adc_host_end_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port(adc_port_if_inst));
   adc_device_end adc_device_end_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .port(adc_port_if_inst),
      .control_word_o(control_word), .shadow_o(shadow), .power_mode_upper_bit_o(pm_hi),
      .power_mode_lower_bit_o(pm_lo), .powered_o(powered), .reference_on_o(reference_on),
      .tracking_o(tracking), .sample_o(sample));
   adc_port_checker adc_port_checker_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .cs_n(adc_port_if_inst.cs_n), .wr_n(adc_port_if_inst.wr_n), .word_mode(adc_port_if_inst.word_mode),
      .shadow_sel(adc_port_if_inst.shadow_sel), .data_bus(adc_port_if_inst.data_bus),
      .conversion_start_n(adc_port_if_inst.conversion_start_n),
      .conversion_clock_in(adc_port_if_inst.conversion_clock_in), .busy(adc_port_if_inst.busy));
   // ----------------------------------------
   // report and compare
   // ----------------------------------------
   task finish_test;
      $display("comparisons %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   // waitrequest is read before the edge's updates land, so this is the taking edge
   task wait_ack;
      int n;
      for (n = 0; n < 1000; n++) begin
         @(posedge core_clk_i);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 1000) begin
         bad_count++;
         finish_test();
      end
   endtask
   task av_write(input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask
   task av_read(input logic [4:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task wait_idle;
      int n;
      for (n = 0; n < 1000; n++) begin
         av_read(`REG_STATUS, rd);
         if (rd[0] === 1'b0) break;
      end
      if (n == 1000) begin
         bad_count++;
         finish_test();
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      chk({20'h0, control_word}, 32'h0);
      chk({24'h0, shadow}, 32'h0);
      chk({30'h0, pm_hi, pm_lo}, 32'h0);
      chk({29'h0, powered, reference_on, tracking}, 32'h6);
      av_read(`REG_CFG, rd);
      chk(rd, 32'h1);
      av_write(5'h18, 32'hffff);
      av_read(5'h14, rd);
      chk(rd, 32'h0);
      av_write(`REG_CTRL, 32'ha5c);
      wait_idle();
      chk({20'h0, control_word}, 32'ha5c);
      av_write(`REG_SHADOW, 32'h3c);
      wait_idle();
      chk({24'h0, shadow}, 32'h3c);
      // byte mode: two link writes for the control word, one for the shadow
      av_write(`REG_CFG, 32'h0);
      av_write(`REG_CTRL, 32'h7b0);
      wait_idle();
      chk({20'h0, control_word}, 32'h7b0);
      av_write(`REG_SHADOW, 32'hc3);
      wait_idle();
      chk({24'h0, shadow}, 32'hc3);
      av_write(`REG_CONV, 32'h0);
      wait_idle();
      chk({29'h0, powered, reference_on, tracking}, 32'h7);
      // word mode, external reference; each power mode after one conversion request
      av_write(`REG_CFG, 32'h3);
      for (int i = 0; i < 4; i++) begin
         cw = 12'h7b0 | 12'(i);
         av_write(`REG_CTRL, {20'h0, cw});
         wait_idle();
         av_write(`REG_CONV, 32'h0);
         wait_idle();
         chk({30'h0, pm_hi, pm_lo}, {30'h0, cw[1:0]});
         chk({20'h0, control_word}, {20'h0, cw});
         chk({29'h0, powered, reference_on, tracking}, {29'h0, pwr_exp[i]});
         av_read(`REG_STATUS, rd);
         chk({28'h0, rd[3:1]}, {28'h0, cw[1:0], 1'b0});
      end
      av_write(`REG_CTRL, 32'h7b0);
      wait_idle();
      chk({29'h0, powered, reference_on, tracking}, 32'h7);
      // a start right after leaving full shutdown must wait out the 200-cycle power-up
      t0 = cyc;
      av_write(`REG_CONV, 32'h0);
      wait_idle();
      chk({31'h0, (cyc - t0) > 200}, 32'h1);
      chk(n_sample, 5);
      finish_test();
   end
endmodule
